// [design/ssrm_map.svh]
// offsets, field positions, reset values and timing counts of the start-up sequencer
`ifndef SSRM_MAP_SVH
`define SSRM_MAP_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define SSRM_CLK_PS 25000

// ----------------------------------------------------------------------
// times in their own unit (ps), as printed
// ----------------------------------------------------------------------
`define SSRM_T_POD_PS 285000000
`define SSRM_T_DISCH_PS 125000000
`define SSRM_T_DETECT_PS 32000000
`define SSRM_T_SS_INT_PS 1500000000
`define SSRM_T_SS_FULL_PS 2000000000
`define SSRM_T_PG_DLY_PS 1060000000

// ----------------------------------------------------------------------
// derived cycle counts (least times round up)
// ----------------------------------------------------------------------
`define SSRM_CYC(t) (((t) + `SSRM_CLK_PS - 1) / `SSRM_CLK_PS)
`define SSRM_POD_CYC `SSRM_CYC(`SSRM_T_POD_PS)
`define SSRM_DISCH_CYC `SSRM_CYC(`SSRM_T_DISCH_PS)
`define SSRM_DETECT_CYC `SSRM_CYC(`SSRM_T_DETECT_PS)
`define SSRM_SS_INT_CYC `SSRM_CYC(`SSRM_T_SS_INT_PS)
`define SSRM_SS_FULL_CYC `SSRM_CYC(`SSRM_T_SS_FULL_PS)
`define SSRM_PG_DLY_CYC `SSRM_CYC(`SSRM_T_PG_DLY_PS)

// ----------------------------------------------------------------------
// register port
// ----------------------------------------------------------------------
`define SSRM_ADDR_STATUS 4'h0
`define SSRM_ADDR_CTRL 4'h4
`define SSRM_CTRL_RST 1'h0
`define SSRM_CTRL_HOLD_BIT 0
// status fields
`define SSRM_ST_STATE_LSB 0
`define SSRM_ST_FREQ_LSB 8
`define SSRM_ST_FORCED_CONTINUOUS_CONDUCTION_BIT 10
`define SSRM_ST_EXTREF_BIT 11
`define SSRM_ST_REFSEL_BIT 12
`define SSRM_ST_OK_BIT 13
`define SSRM_ST_SWEN_BIT 14

`endif

// [design/ssrm_pkg.sv]
// types of the start-up sequencer
package ssrm_pkg;

  // sequence states, one-hot
  typedef enum logic [7:0] {
    SSRM_OFF = 8'h01,
    SSRM_DISCH = 8'h02,
    SSRM_DETECT = 8'h04,
    SSRM_POD_END = 8'h08,
    SSRM_RAMP = 8'h10,
    SSRM_PG_WAIT = 8'h20,
    SSRM_RUN = 8'h40
  } ssrm_state_e;

  // strap ladder code from the strap sense comparators
  typedef enum logic [2:0] {
    SSRM_STRAP_GND = 3'h0,
    SSRM_STRAP_30K1 = 3'h1,
    SSRM_STRAP_60K4 = 3'h2,
    SSRM_STRAP_121K = 3'h3,
    SSRM_STRAP_243K = 3'h4,
    SSRM_STRAP_VCC = 3'h5,
    SSRM_STRAP_OPEN = 3'h7
  } ssrm_strap_e;

  // switching frequency choice
  typedef enum logic [1:0] {
    SSRM_F600 = 2'h0,
    SSRM_F800 = 2'h1,
    SSRM_F1000 = 2'h2
  } ssrm_freq_e;

  // latched operating mode
  typedef struct packed {
    logic forced_continuous_conduction;
    ssrm_freq_e freq;
  } ssrm_mode_s;

  // analog comparator and pin levels, all asynchronous to clk_sys
  typedef struct packed {
    logic enable;
    logic uvlo_ok;
    logic refin_above_89;
    logic fb_near_ref;
    logic ss_above_50mv;
    logic ss_ramp_done;
    logic [2:0] strap;
  } ssrm_sense_s;

endpackage

// [design/ssrm_sequencer.sv]
// power-on delay, reference detection, soft-start and supply-ok sequencer
`timescale 1ns/1ps
`include "ssrm_map.svh"

module ssrm_sequencer
  import ssrm_pkg::*;
#(
  parameter int POD_CYC = `SSRM_POD_CYC,
  parameter int DISCH_CYC = `SSRM_DISCH_CYC,
  parameter int DETECT_CYC = `SSRM_DETECT_CYC,
  parameter int SS_INT_CYC = `SSRM_SS_INT_CYC,
  parameter int SS_FULL_CYC = `SSRM_SS_FULL_CYC,
  parameter int PG_DLY_CYC = `SSRM_PG_DLY_CYC,
  parameter int RAMP_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // analog sense levels
  input wire ssrm_sense_s sense,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // analog controls
  output logic ss_discharge_en,
  output logic [RAMP_W-1:0] int_ramp_code,
  output logic switching_en,
  output logic thresh_ref_from_pin,
  output logic loop_ref_from_pin,
  output logic ss_done,
  output logic supply_ok_output,
  output ssrm_mode_s mode
);

  localparam int CNT_W = 18;

  // ----------------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------------
  function automatic ssrm_mode_s strap_decode(input logic [2:0] code);
    ssrm_mode_s m;
    m = '{forced_continuous_conduction: 1'b0, freq: SSRM_F600};
    case (code)
      SSRM_STRAP_VCC: m = '{forced_continuous_conduction: 1'b0, freq: SSRM_F600};
      SSRM_STRAP_243K: m = '{forced_continuous_conduction: 1'b0, freq: SSRM_F800};
      SSRM_STRAP_121K: m = '{forced_continuous_conduction: 1'b0, freq: SSRM_F1000};
      SSRM_STRAP_60K4: m = '{forced_continuous_conduction: 1'b1, freq: SSRM_F1000};
      SSRM_STRAP_30K1: m = '{forced_continuous_conduction: 1'b1, freq: SSRM_F800};
      SSRM_STRAP_GND: m = '{forced_continuous_conduction: 1'b1, freq: SSRM_F600};
      default: m = '{forced_continuous_conduction: 1'b0, freq: SSRM_F600};
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  ssrm_sense_s sense_meta_ff;
  ssrm_sense_s sense_ff;

  // two stages for every analog level; only the second stage is read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_meta_ff <= '0;
      sense_ff <= '0;
    end else begin
      sense_meta_ff <= sense;
      sense_ff <= sense_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  logic hold_ff;

  // hold keeps the sequencer parked in off, like a removed enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_ff <= `SSRM_CTRL_RST;
    end else if (reg_wr && reg_addr == `SSRM_ADDR_CTRL) begin
      hold_ff <= reg_wdata[`SSRM_CTRL_HOLD_BIT];
    end
  end

  // power is allowed only with enable, no undervoltage and no hold
  logic power_ok;
  assign power_ok = sense_ff.enable && sense_ff.uvlo_ok && !hold_ff;

  // ----------------------------------------------------------------------
  // sequence state machine
  // ----------------------------------------------------------------------
  ssrm_state_e state_ff;
  ssrm_state_e nxt_state;
  logic [CNT_W-1:0] pod_cnt_ff;
  logic [CNT_W-1:0] ramp_cnt_ff;
  logic [CNT_W-1:0] pg_cnt_ff;
  logic ext_ref_ff;
  logic ext_ramp_done_ff;
  logic pod_last;
  logic disch_last;
  logic detect_last;
  logic ramp_full;
  logic ramps_done;

  assign pod_last = pod_cnt_ff == CNT_W'(POD_CYC - 1);
  assign disch_last = pod_cnt_ff == CNT_W'(DISCH_CYC - 1);
  assign detect_last = pod_cnt_ff == CNT_W'(DISCH_CYC + DETECT_CYC - 1);
  assign ramp_full = ramp_cnt_ff == CNT_W'(SS_FULL_CYC);
  // with no external reference the slower of both ramps must finish
  assign ramps_done = ramp_full && (ext_ref_ff || ext_ramp_done_ff);

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SSRM_OFF: if (power_ok) nxt_state = SSRM_DISCH;
      SSRM_DISCH: if (disch_last) nxt_state = SSRM_DETECT;
      SSRM_DETECT: if (detect_last) nxt_state = SSRM_POD_END;
      SSRM_POD_END: if (pod_last) nxt_state = SSRM_RAMP;
      SSRM_RAMP: if (ramps_done) nxt_state = SSRM_PG_WAIT;
      SSRM_PG_WAIT: if (pg_cnt_ff == CNT_W'(PG_DLY_CYC - 1)) nxt_state = SSRM_RUN;
      SSRM_RUN: nxt_state = SSRM_RUN;
      default: nxt_state = SSRM_OFF;
    endcase
    if (!power_ok) begin
      nxt_state = SSRM_OFF;
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= SSRM_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // power-on delay timer
  // ----------------------------------------------------------------------
  // one counter spans the whole delay, so discharge and detection windows
  // are slices of it and cannot drift apart
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pod_cnt_ff <= '0;
    end else if (state_ff == SSRM_OFF || nxt_state == SSRM_OFF) begin
      pod_cnt_ff <= '0;
    end else if (state_ff == SSRM_DISCH || state_ff == SSRM_DETECT ||
                 state_ff == SSRM_POD_END) begin
      pod_cnt_ff <= pod_cnt_ff + CNT_W'(1);
    end
  end

  // pin discharge covers the first slice of the power-on delay
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ss_discharge_en <= 1'b0;
    end else begin
      ss_discharge_en <= (nxt_state == SSRM_DISCH);
    end
  end

  // ----------------------------------------------------------------------
  // external reference detection
  // ----------------------------------------------------------------------
  // the pin must stay above the threshold through the whole window; one low
  // sample means a leaking capacitor, not a source
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_ref_ff <= 1'b0;
    end else if (state_ff == SSRM_OFF) begin
      ext_ref_ff <= 1'b0;
    end else if (state_ff == SSRM_DISCH && disch_last) begin
      ext_ref_ff <= 1'b1;
    end else if (state_ff == SSRM_DETECT && !sense_ff.refin_above_89) begin
      ext_ref_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // strap latch
  // ----------------------------------------------------------------------
  // sampled only inside the power-on delay; later strap moves are ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode <= '{forced_continuous_conduction: 1'b0, freq: SSRM_F600};
    end else if (state_ff == SSRM_OFF) begin
      mode <= '{forced_continuous_conduction: 1'b0, freq: SSRM_F600};
    end else if (state_ff == SSRM_POD_END && pod_last) begin
      mode <= strap_decode(sense_ff.strap);
    end
  end

  // ----------------------------------------------------------------------
  // soft-start ramp
  // ----------------------------------------------------------------------
  // counts from ramp start to the 2 ms end and stays there
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ramp_cnt_ff <= '0;
    end else if (state_ff == SSRM_OFF || nxt_state == SSRM_OFF) begin
      ramp_cnt_ff <= '0;
    end else if (state_ff == SSRM_RAMP && !ramp_full) begin
      ramp_cnt_ff <= ramp_cnt_ff + CNT_W'(1);
    end
  end

  // internal ramp code reaches full scale at 1.5 ms; the analog side takes
  // the lower of this and the pin, so the slower ramp wins
  logic [CNT_W+RAMP_W-1:0] ramp_scaled;
  assign ramp_scaled = ramp_cnt_ff * (CNT_W+RAMP_W)'((1 << RAMP_W) - 1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_ramp_code <= '0;
    end else if (state_ff != SSRM_RAMP && state_ff != SSRM_PG_WAIT &&
                 state_ff != SSRM_RUN) begin
      int_ramp_code <= '0;
    end else if (ramp_cnt_ff >= CNT_W'(SS_INT_CYC)) begin
      int_ramp_code <= '1;
    end else begin
      int_ramp_code <= RAMP_W'(ramp_scaled / (CNT_W+RAMP_W)'(SS_INT_CYC));
    end
  end

  // external ramp finish is sticky: once the pin has reached the reference
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_ramp_done_ff <= 1'b0;
    end else if (state_ff == SSRM_OFF) begin
      ext_ramp_done_ff <= 1'b0;
    end else if (state_ff == SSRM_RAMP && sense_ff.ss_ramp_done) begin
      ext_ramp_done_ff <= 1'b1;
    end
  end

  // power stage held off until the pin rises past 50 mV
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      switching_en <= 1'b0;
    end else if (nxt_state == SSRM_OFF || state_ff == SSRM_OFF ||
                 state_ff == SSRM_DISCH || state_ff == SSRM_DETECT ||
                 state_ff == SSRM_POD_END) begin
      switching_en <= 1'b0;
    end else if (sense_ff.ss_above_50mv) begin
      switching_en <= 1'b1;
    end
  end

  // soft-start done latches the feedback comparator once ramping
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ss_done <= 1'b0;
    end else if (nxt_state == SSRM_OFF || state_ff == SSRM_OFF) begin
      ss_done <= 1'b0;
    end else if (state_ff == SSRM_RAMP || state_ff == SSRM_PG_WAIT ||
                 state_ff == SSRM_RUN) begin
      ss_done <= ss_done | sense_ff.fb_near_ref;
    end
  end

  // ----------------------------------------------------------------------
  // supply-ok delay
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pg_cnt_ff <= '0;
    end else if (state_ff != SSRM_PG_WAIT || nxt_state == SSRM_OFF) begin
      pg_cnt_ff <= '0;
    end else begin
      pg_cnt_ff <= pg_cnt_ff + CNT_W'(1);
    end
  end

  // supply ok drops at once on enable loss or undervoltage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      supply_ok_output <= 1'b0;
    end else begin
      supply_ok_output <= (nxt_state == SSRM_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // reference selection
  // ----------------------------------------------------------------------
  // thresholds use the pin when a source was found, or once supply ok has
  // risen; the loop itself always follows the pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      thresh_ref_from_pin <= 1'b0;
      loop_ref_from_pin <= 1'b0;
    end else begin
      thresh_ref_from_pin <= (nxt_state != SSRM_OFF) &&
                             ((ext_ref_ff && (state_ff == SSRM_POD_END ||
                               state_ff == SSRM_RAMP || state_ff == SSRM_PG_WAIT ||
                               state_ff == SSRM_RUN)) ||
                              supply_ok_output);
      loop_ref_from_pin <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  // unmapped addresses read zero; data stands one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == `SSRM_ADDR_STATUS) begin
      reg_rdata <= '0;
      reg_rdata[`SSRM_ST_STATE_LSB +: 8] <= state_ff;
      reg_rdata[`SSRM_ST_FREQ_LSB +: 2] <= mode.freq;
      reg_rdata[`SSRM_ST_FORCED_CONTINUOUS_CONDUCTION_BIT] <= mode.forced_continuous_conduction;
      reg_rdata[`SSRM_ST_EXTREF_BIT] <= ext_ref_ff;
      reg_rdata[`SSRM_ST_REFSEL_BIT] <= thresh_ref_from_pin;
      reg_rdata[`SSRM_ST_OK_BIT] <= supply_ok_output;
      reg_rdata[`SSRM_ST_SWEN_BIT] <= switching_en;
    end else if (reg_rd && reg_addr == `SSRM_ADDR_CTRL) begin
      reg_rdata <= {31'h0, hold_ff};
    end else if (reg_rd) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // ssrm_sequencer

// [verification/ssrm_sequencer_chk.sv]
// port-level assertions for the start-up sequencer
`timescale 1ns/1ps
module ssrm_sequencer_chk
  import ssrm_pkg::*;
#(
  parameter int POD_CYC = 20,
  parameter int DISCH_CYC = 10,
  parameter int SS_FULL_CYC = 40,
  parameter int PG_DLY_CYC = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // watched ports
  input wire ssrm_sense_s sense,
  input wire logic ss_discharge_en,
  input wire logic switching_en,
  input wire logic thresh_ref_from_pin,
  input wire logic loop_ref_from_pin,
  input wire logic supply_ok_output,
  input wire ssrm_mode_s mode
);
  // earliest supply ok after discharge ends; slack covers pipeline offsets
  localparam int OK_MIN = POD_CYC - DISCH_CYC + SS_FULL_CYC + PG_DLY_CYC - 4;
  // wide enough for the full-length delays, so neither counter wraps at the real timing
  logic [19:0] dlen_ff;
  logic [19:0] since_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // length of the discharge pulse
  always_ff @(posedge clk_sys) begin
    if (rst || !ss_discharge_en) dlen_ff <= 20'h00000;
    else dlen_ff <= dlen_ff + 20'h00001;
  end
  // cycles since discharge ended, saturating so a long run cannot wrap
  always_ff @(posedge clk_sys) begin
    if (rst || ss_discharge_en) since_ff <= 20'h00000;
    else if (since_ff != 20'hfffff) since_ff <= since_ff + 20'h00001;
  end
  AST_DISCH_LEN: assert property (
    $fell(ss_discharge_en) |-> dlen_ff inside {[DISCH_CYC:DISCH_CYC+1]}
  ) else $error("discharge pulse length wrong");
  AST_OK_NOT_EARLY: assert property (
    $rose(supply_ok_output) |-> since_ff >= OK_MIN
  ) else $error("supply ok came too early");
  AST_THRESH_AFTER_OK: assert property (
    $rose(supply_ok_output) |=> thresh_ref_from_pin
  ) else $error("thresholds not on pin after supply ok");
  AST_QUIET_IN_DISCH: assert property (
    ss_discharge_en |-> !switching_en
  ) else $error("switching during discharge");
  AST_SW_NEEDS_50MV: assert property (
    $rose(switching_en) |-> $past(sense.ss_above_50mv, 3)
  ) else $error("switching before pin above 50 mV");
  AST_OK_DROPS: assert property (
    !sense.enable [*5] |-> !supply_ok_output
  ) else $error("supply ok held without enable");
  AST_POD_CLEAN: assert property (
    ss_discharge_en |-> !supply_ok_output && !thresh_ref_from_pin
  ) else $error("stale result during discharge");
  AST_MODE_HELD: assert property (
    supply_ok_output && $past(supply_ok_output) |-> $stable(mode)
  ) else $error("mode moved after latch");
  AST_LOOP_REF: assert property (
    !$past(rst) |-> loop_ref_from_pin
  ) else $error("loop not on pin reference");
  COV_OK_EXT: cover property ($rose(supply_ok_output) && thresh_ref_from_pin);
  COV_OK_INT: cover property ($rose(supply_ok_output) && !thresh_ref_from_pin);
  COV_OK_LOST: cover property ($fell(supply_ok_output));
endmodule // ssrm_sequencer_chk

bind ssrm_sequencer ssrm_sequencer_chk #(
  .POD_CYC(POD_CYC),
  .DISCH_CYC(DISCH_CYC),
  .SS_FULL_CYC(SS_FULL_CYC),
  .PG_DLY_CYC(PG_DLY_CYC)
) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .sense(sense),
  .ss_discharge_en(ss_discharge_en),
  .switching_en(switching_en),
  .thresh_ref_from_pin(thresh_ref_from_pin),
  .loop_ref_from_pin(loop_ref_from_pin),
  .supply_ok_output(supply_ok_output),
  .mode(mode)
);

// [verification/ssrm_far_side.sv]
// far side model: reference source or soft-start capacitor on the pin, and strap resistor
`timescale 1ns/1ps
module ssrm_far_side (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // scenario controls
  input wire logic ext_ref_on,
  input wire logic ref_sag,
  input wire logic [9:0] cap_cyc,
  input wire logic [2:0] strap_code,
  // pin activity from the sequencer
  input wire logic ss_discharge_en,
  input wire logic ramp_active,
  // comparator levels
  output logic refin_above_89,
  output logic ss_above_50mv,
  output logic ss_ramp_done,
  output logic fb_near_ref,
  output logic [2:0] strap
);
  logic [9:0] pin_ff;
  // capacitor charge: emptied by the discharge switch, charged only while the ramp runs
  always_ff @(posedge clk_sys) begin
    if (rst || ss_discharge_en) pin_ff <= 10'h000;
    else if (ramp_active && pin_ff < cap_cyc) pin_ff <= pin_ff + 10'h001;
  end
  // stiff source holds the pin above the detect level unless the bench makes it sag
  assign refin_above_89 = ext_ref_on && !ref_sag;
  // the source stays at one dc level, so range and slew limits hold trivially
  assign ss_above_50mv = ext_ref_on || pin_ff >= 10'h002;
  assign ss_ramp_done = ext_ref_on || pin_ff >= cap_cyc;
  // feedback tracks the pin, so it arrives when the pin does
  assign fb_near_ref = ss_ramp_done;
  assign strap = strap_code;
endmodule // ssrm_far_side

// [verification/ssrm_sequencer_tb.sv]
// self-checking bench for the start-up sequencer
`timescale 1ns/1ps
module ssrm_sequencer_tb;
  import ssrm_pkg::*;
  // one row: strap code, reference present, expected {forced_continuous_conduction, freq}
  typedef struct packed {
    logic [2:0] strap;
    logic ext;
    ssrm_mode_s exp;
  } ssrm_row_s;
  ssrm_row_s rows [8] = '{'{3'h0, 1'b0, 3'h4}, '{3'h1, 1'b1, 3'h5}, '{3'h2, 1'b0, 3'h6},
    '{3'h3, 1'b1, 3'h2}, '{3'h4, 1'b0, 3'h1}, '{3'h5, 1'b1, 3'h0}, '{3'h7, 1'b0, 3'h0},
    '{3'h6, 1'b1, 3'h0}};
  // shortened timing set so a full start-up takes tens of cycles, not over a hundred thousand
  localparam int POD = 20;
  localparam int DISCH = 10;
  localparam int DETECT = 4;
  localparam int SS_INT = 30;
  localparam int SS_FULL = 40;
  localparam int PG_DLY = 16;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic uv_ok = 1'b1;
  logic ext_on = 1'b0;
  logic sag = 1'b0;
  logic [9:0] cap_cyc = 10'h005;
  logic [2:0] strap_code = 3'h7;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic disch, sw, thresh, loop_ref, ss_done, ok, refin, ss50, ssdone, fbn, thr;
  logic [7:0] ramp_code;
  logic [2:0] strap;
  logic [31:0] rd;
  ssrm_mode_s mode;
  ssrm_sense_s sense;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  assign sense = {en, uv_ok, refin, fbn, ss50, ssdone, strap};
  always #12.5 clk_sys = ~clk_sys;
  ssrm_sequencer #(.POD_CYC(POD), .DISCH_CYC(DISCH), .DETECT_CYC(DETECT), .SS_INT_CYC(SS_INT),
    .SS_FULL_CYC(SS_FULL), .PG_DLY_CYC(PG_DLY)) uut (.clk_sys(clk_sys), .rst(rst), .sense(sense),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ss_discharge_en(disch), .int_ramp_code(ramp_code),
    .switching_en(sw), .thresh_ref_from_pin(thresh), .loop_ref_from_pin(loop_ref),
    .ss_done(ss_done), .supply_ok_output(ok), .mode(mode));
  ssrm_far_side u_far (.clk_sys(clk_sys), .rst(rst), .ext_ref_on(ext_on), .ref_sag(sag),
    .cap_cyc(cap_cyc), .strap_code(strap_code), .ss_discharge_en(disch),
    .ramp_active(|ramp_code), .refin_above_89(refin), .ss_above_50mv(ss50),
    .ss_ramp_done(ssdone), .fb_near_ref(fbn), .strap(strap));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard: the whole run needs about 1150 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      $display("ERROR %0t timeout", $time);
      report_and_stop();
    end
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // start up and count cycles from the end of discharge to supply ok
  task automatic start_run(input logic [2:0] s, input logic e, output int k, output logic t);
    k = 0;
    @(posedge clk_sys);
    en <= 1'b1;
    strap_code <= s;
    ext_on <= e;
    while (!disch) tick();
    while (disch) tick();
    while (!ok && k < 400) begin
      t = thresh;
      tick();
      k++;
    end
  endtask
  // drop enable or supply, then supply ok, thresholds, switching, discharge and mode must be cleared
  task automatic stop_run(input logic by_uv);
    @(posedge clk_sys);
    if (by_uv) uv_ok <= 1'b0;
    else en <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk({ok, thresh, sw, disch, mode}, 7'h00, "cleared after stop");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    tick();
    chk({ok, thresh, sw, disch, ss_done, loop_ref, mode, ramp_code}, 17'h00800, "reset");
    rdr(4'h0, rd);
    chk(rd, 32'h1, "status after reset");
    wr(4'hc, 32'hffffffff);
    rdr(4'h8, rd);
    chk(rd, 32'h0, "unmapped read");
    rdr(4'h4, rd);
    chk(rd, 32'h0, "ctrl after reset");
    // every strap code, alternating internal and external reference
    foreach (rows[i]) begin
      start_run(rows[i].strap, rows[i].ext, n, thr);
      chk(n >= 62 && n <= 70, 1'b1, "ok delay");
      chk(thr, rows[i].ext, "threshold source before ok");
      chk(mode, rows[i].exp, "latched mode");
      chk({sw, ss_done, ramp_code}, 10'h3ff, "ramp outputs at ok");
      @(posedge clk_sys);
      strap_code <= ~rows[i].strap;
      repeat (4) tick();
      chk({thresh, mode}, {1'b1, rows[i].exp}, "after ok");
      rdr(4'h0, rd);
      chk(rd, {17'h0, 3'h7, rows[i].ext, rows[i].exp, 8'h40}, "status in run");
      stop_run(1'b0);
    end
    // slow capacitor ramp outlasts the internal one
    @(posedge clk_sys);
    cap_cyc <= 10'd100;
    start_run(3'h7, 1'b0, n, thr);
    chk(n >= 124 && n <= 136, 1'b1, "slow ramp ok delay");
    stop_run(1'b0);
    // reference too weak to hold the detect level
    @(posedge clk_sys);
    cap_cyc <= 10'h005;
    sag <= 1'b1;
    start_run(3'h7, 1'b1, n, thr);
    chk(thr, 1'b0, "weak reference thresholds");
    rdr(4'h0, rd);
    chk(rd[11], 1'b0, "weak reference detect");
    stop_run(1'b0);
    // undervoltage in mid-ramp, parked by the hold bit, then a fresh start
    @(posedge clk_sys);
    sag <= 1'b0;
    en <= 1'b1;
    while (!sw) tick();
    stop_run(1'b1);
    wr(4'h4, 32'h1);
    uv_ok <= 1'b1;
    repeat (30) tick();
    rdr(4'h0, rd);
    chk({disch, rd}, 33'h1, "parked by hold");
    rdr(4'h4, rd);
    chk(rd, 32'h1, "ctrl readback");
    wr(4'h4, 32'h0);
    start_run(3'h2, 1'b0, n, thr);
    chk({n >= 62 && n <= 70, mode}, {1'b1, 3'h6}, "restart");
    stop_run(1'b0);
    report_and_stop();
  end
endmodule // ssrm_sequencer_tb
